// ---- mdcb_config_bank.sv ----
/*
  Two 16-bit configuration registers of a sensorless three-phase motor
  driver, with their fields decoded into ready-to-use settings.
  Assumes a serial host bus front end in the same clock domain that gives
  a one-cycle write strobe with address and data, and reads data
  registered here one clock edge after an address.
*/
// What this block does
// R1 - first register bit 15: clear means analog speed pin, set means pulse width
// R2 - switching-rate bit: zero gives 25 kHz, one gives 50 kHz
// R3 - lock threshold code picks high 3/2 or 2, low 3/4 or 1/2 nominal
// R4 - bit 11 set enables inductive surge guard
// R5 - bit 10 set enables mechanical surge guard
// R6 - bit 9 clear clamps to supply, set clamps to 24 V
// R7 - bit 8 clear brakes on sense release, set goes high impedance
// R8 - bit 7 clear allows closed loop transfer, set stays open loop
// R9 - ramp code 000 is immediate, others ramp ever slower
// R10 - minimum duty floor 5% for codes 00/10, 10% for 01/11
// R11 - below cutoff zero duty for 00/01, full duty for 10/11
// R12 - edge speed codes give 35, 50, 80, 120 V per microsecond
// R13 - second register at 0x96, resets zero, bit 7 reads zero
// R14 - bits 15:14 give lead angle 30, 60, 90, 120 degrees
// R15 - bits 13:10 sense current: 0 off, 1 is 0.4 A, else 0.2A(n+1)
// R16 - bits 9:8 select sense tick 12, 24, 47 or 95 Hz
// R17 - bits 4:0 give dead time of (n+1) steps of 40 ns
// R18 - fields hold last write until reset; reads return contents unchanged
`timescale 1ns/1ps
`include "mdcb_cfg.svh"

module mdcb_config_bank (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // host register port
    input  wire logic                  regWrite,
    input  wire mdcb_pkg::mdcb_addr_t  regAddr,
    input  wire mdcb_pkg::mdcb_word_t  regWrData,
    output mdcb_pkg::mdcb_word_t       regRdData,
    output logic                       regRdHit,
    // first register settings
    output mdcb_pkg::mdcb_src_t        speedSourceSel,
    output mdcb_pkg::mdcb_rate_t       switchingRateSel,
    output logic [1:0]                 torqueConstLockLimits,
    output logic                       lockHighIsDouble,
    output logic                       lockLowIsHalf,
    output logic                       inductiveSurgeGuardOn,
    output logic                       mechanicalSurgeGuardOn,
    output mdcb_pkg::mdcb_clamp_t      mechanicalSurgeClampTarget,
    output mdcb_pkg::mdcb_release_t    senseReleaseBehaviour,
    output logic                       stayOpenLoop,
    output logic [2:0]                 closedRampRate,
    output logic                       rampImmediate,
    output logic [1:0]                 minOnRatioSel,
    output logic [3:0]                 minDutyFloorPct,
    output logic                       cutoffGivesFullDuty,
    output logic [1:0]                 phaseEdgeSpeedSel,
    output logic [6:0]                 edgeRateVoltsPerUs,
    // second register settings
    output logic [1:0]                 postSenseLeadAngle,
    output logic [6:0]                 leadAngleDeg,
    output logic [3:0]                 senseCurrentLevel,
    output logic                       senseDisabled,
    output logic [5:0]                 senseCurrentTenthsA,
    output logic [1:0]                 senseTickSel,
    output logic [6:0]                 senseTickHz,
    output logic [1:0]                 loopGainCoefficient,
    output logic [4:0]                 driverGapTime,
    output logic [6:0]                 driverGapCycles
);
    import mdcb_pkg::*;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    mdcb_word_t speedLoopCfg;
    mdcb_word_t senseDeadCfg;
    wire        hitSpeedLoop = (regAddr == `MDCB_SPEED_LOOP_OFS);
    wire        hitSenseDead = (regAddr == `MDCB_SENSE_DEAD_OFS); // R13
    // unmapped addresses read zero and leave the bank untouched
    wire mdcb_word_t readSel = hitSpeedLoop ? speedLoopCfg :
                               hitSenseDead ? senseDeadCfg : 16'h0000; // R18

    // ------------------------------------------------------------------
    // storage: each field holds its last write until reset
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            speedLoopCfg <= `MDCB_SPEED_LOOP_RST;
            senseDeadCfg <= `MDCB_SENSE_DEAD_RST; // R13
        end else begin
            if (regWrite && hitSpeedLoop) begin
                speedLoopCfg <= regWrData; // R18
            end
            if (regWrite && hitSenseDead) begin
                senseDeadCfg <= regWrData & `MDCB_SENSE_DEAD_WMASK; // R13
            end
        end
    end

    // ------------------------------------------------------------------
    // decode of field meanings, from the next-cycle view of the words
    // ------------------------------------------------------------------
    wire mdcb_word_t next_a = (regWrite && hitSpeedLoop) ? regWrData : speedLoopCfg;
    wire mdcb_word_t next_b = (regWrite && hitSenseDead) ?
                              (regWrData & `MDCB_SENSE_DEAD_WMASK) : senseDeadCfg;
    wire [1:0] lockCode = next_a[`MDCB_LOCK_HI:`MDCB_LOCK_LO];
    wire [1:0] minCode  = next_a[`MDCB_MIN_ON_HI:`MDCB_MIN_ON_LO];
    wire [1:0] edgeCode = next_a[`MDCB_EDGE_HI:`MDCB_EDGE_LO];
    wire [1:0] leadCode = next_b[`MDCB_LEAD_HI:`MDCB_LEAD_LO];
    wire [3:0] currCode = next_b[`MDCB_CURR_HI:`MDCB_CURR_LO];
    wire [1:0] tickCode = next_b[`MDCB_TICK_HI:`MDCB_TICK_LO];
    wire [4:0] gapCode  = next_b[`MDCB_GAP_HI:`MDCB_GAP_LO];

    // edge rate table at a 12 V supply
    wire [6:0] edgeRate = (edgeCode == 2'b00) ? 7'h23 :
                          (edgeCode == 2'b01) ? 7'h32 :
                          (edgeCode == 2'b10) ? 7'h50 : 7'h78; // R12
    // lead angle is 30 degrees per code step plus one
    wire [6:0] leadDeg  = 7'({5'h00, leadCode} + 7'h01) * 7'h1E; // R14
    // sense current in tenths of an amp; code 1 is a special 0.4 A
    // six bits wide, since code 15 gives 3.2 A, which is 32 tenths
    wire [5:0] currTen  = (currCode == 4'h0) ? 6'h00 :
                          (currCode == 4'h1) ? 6'h04 :
                          6'(({2'b00, currCode} + 6'h01) << 1); // R15
    wire [6:0] tickHz   = (tickCode == 2'b00) ? 7'h0C :
                          (tickCode == 2'b01) ? 7'h18 :
                          (tickCode == 2'b10) ? 7'h2F : 7'h5F; // R16
    // gap in clock cycles; 32 steps of two cycles fit in seven bits
    wire [6:0] gapCyc   = 7'(({2'b00, gapCode} + 7'h01) * 7'(`MDCB_GAP_STEP_CYC)); // R17

    // ------------------------------------------------------------------
    // registered outputs; settings mirrored one edge after the host write, read data one edge after the address
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            regRdData                  <= 16'h0000;
            regRdHit                   <= 1'b0;
            speedSourceSel             <= MDCB_SRC_ANALOG;
            switchingRateSel           <= MDCB_RATE_25K;
            torqueConstLockLimits      <= 2'b00;
            lockHighIsDouble           <= 1'b0;
            lockLowIsHalf              <= 1'b0;
            inductiveSurgeGuardOn      <= 1'b0;
            mechanicalSurgeGuardOn     <= 1'b0;
            mechanicalSurgeClampTarget <= MDCB_CLAMP_SUPPLY;
            senseReleaseBehaviour      <= MDCB_REL_BRAKE;
            stayOpenLoop               <= 1'b0;
            closedRampRate             <= 3'b000;
            rampImmediate              <= 1'b1;
            minOnRatioSel              <= 2'b00;
            minDutyFloorPct            <= 4'h5;
            cutoffGivesFullDuty        <= 1'b0;
            phaseEdgeSpeedSel          <= 2'b00;
            edgeRateVoltsPerUs         <= 7'h23;
            postSenseLeadAngle         <= 2'b00;
            leadAngleDeg               <= 7'h1E;
            senseCurrentLevel          <= 4'h0;
            senseDisabled              <= 1'b1;
            senseCurrentTenthsA        <= 6'h00;
            senseTickSel               <= 2'b00;
            senseTickHz                <= 7'h0C;
            loopGainCoefficient        <= 2'b00;
            driverGapTime              <= 5'h00;
            driverGapCycles            <= 7'h02;
        end else begin
            regRdData                  <= readSel; // R18
            regRdHit                   <= hitSpeedLoop | hitSenseDead;
            speedSourceSel             <= mdcb_src_t'(next_a[`MDCB_SPEED_SRC_BIT]); // R1
            switchingRateSel           <= mdcb_rate_t'(next_a[`MDCB_RATE_BIT]); // R2
            torqueConstLockLimits      <= lockCode; // R3
            lockHighIsDouble           <= lockCode[0]; // R3
            lockLowIsHalf              <= lockCode[1]; // R3
            inductiveSurgeGuardOn      <= next_a[`MDCB_IND_GUARD_BIT]; // R4
            mechanicalSurgeGuardOn     <= next_a[`MDCB_MECH_GUARD_BIT]; // R5
            mechanicalSurgeClampTarget <= mdcb_clamp_t'(next_a[`MDCB_CLAMP_BIT]); // R6
            senseReleaseBehaviour      <= mdcb_release_t'(next_a[`MDCB_RELEASE_BIT]); // R7
            stayOpenLoop               <= next_a[`MDCB_OPEN_LOOP_BIT]; // R8
            closedRampRate             <= next_a[`MDCB_RAMP_HI:`MDCB_RAMP_LO]; // R9
            rampImmediate              <= (next_a[`MDCB_RAMP_HI:`MDCB_RAMP_LO] == 3'b000); // R9
            minOnRatioSel              <= minCode; // R10
            minDutyFloorPct            <= minCode[0] ? 4'hA : 4'h5; // R10
            cutoffGivesFullDuty        <= minCode[1]; // R11
            phaseEdgeSpeedSel          <= edgeCode; // R12
            edgeRateVoltsPerUs         <= edgeRate;
            postSenseLeadAngle         <= leadCode; // R14
            leadAngleDeg               <= leadDeg;
            senseCurrentLevel          <= currCode; // R15
            senseDisabled              <= (currCode == 4'h0); // R15
            senseCurrentTenthsA        <= currTen;
            senseTickSel               <= tickCode; // R16
            senseTickHz                <= tickHz;
            loopGainCoefficient        <= next_b[`MDCB_GAIN_HI:`MDCB_GAIN_LO];
            driverGapTime              <= gapCode; // R17
            driverGapCycles            <= gapCyc;
        end
    end

endmodule

// ---- mdcb_cfg.svh ----
/*
  Register offsets, field positions, reset values and timing figures of the
  motor drive configuration bank.
  Assumes inclusion by bare name from the bank module.
*/
`ifndef MDCB_CFG_SVH
`define MDCB_CFG_SVH

// ------------------------------------------------------------------
// register offsets (byte addresses on the serial host bus)
// ------------------------------------------------------------------
`define MDCB_SPEED_LOOP_OFS    8'h95
`define MDCB_SENSE_DEAD_OFS    8'h96

// ------------------------------------------------------------------
// reset values and write mask
// ------------------------------------------------------------------
`define MDCB_SPEED_LOOP_RST    16'h0000
`define MDCB_SENSE_DEAD_RST    16'h0000
`define MDCB_SENSE_DEAD_WMASK  16'hFF7F

// ------------------------------------------------------------------
// first register field positions
// ------------------------------------------------------------------
`define MDCB_SPEED_SRC_BIT     15
`define MDCB_RATE_BIT          14
`define MDCB_LOCK_HI           13
`define MDCB_LOCK_LO           12
`define MDCB_IND_GUARD_BIT     11
`define MDCB_MECH_GUARD_BIT    10
`define MDCB_CLAMP_BIT         9
`define MDCB_RELEASE_BIT       8
`define MDCB_OPEN_LOOP_BIT     7
`define MDCB_RAMP_HI           6
`define MDCB_RAMP_LO           4
`define MDCB_MIN_ON_HI         3
`define MDCB_MIN_ON_LO         2
`define MDCB_EDGE_HI           1
`define MDCB_EDGE_LO           0

// ------------------------------------------------------------------
// second register field positions
// ------------------------------------------------------------------
`define MDCB_LEAD_HI           15
`define MDCB_LEAD_LO           14
`define MDCB_CURR_HI           13
`define MDCB_CURR_LO           10
`define MDCB_TICK_HI           9
`define MDCB_TICK_LO           8
`define MDCB_RSVD_BIT          7
`define MDCB_GAIN_HI           6
`define MDCB_GAIN_LO           5
`define MDCB_GAP_HI            4
`define MDCB_GAP_LO            0

// ------------------------------------------------------------------
// timing: driver gap step and clock period
// ------------------------------------------------------------------
`define MDCB_GAP_STEP_NS       40
`define MDCB_CLOCK_NS          20
`define MDCB_GAP_STEP_CYC      ((`MDCB_GAP_STEP_NS + `MDCB_CLOCK_NS - 1) / `MDCB_CLOCK_NS)

`endif

// ---- mdcb_pkg.sv ----
/*
  Types of the motor drive configuration bank.
  Assumes mdcb_cfg.svh is on the include path.
*/
package mdcb_pkg;

    // speed command source
    typedef enum logic {MDCB_SRC_ANALOG = 1'b0, MDCB_SRC_PULSE = 1'b1} mdcb_src_t;

    // switching rate, 25 kHz or 50 kHz
    typedef enum logic {MDCB_RATE_25K = 1'b0, MDCB_RATE_50K = 1'b1} mdcb_rate_t;

    // state of the phases on sense release
    typedef enum logic {MDCB_REL_BRAKE = 1'b0, MDCB_REL_HIZ = 1'b1} mdcb_release_t;

    // mechanical surge clamp target
    typedef enum logic {MDCB_CLAMP_SUPPLY = 1'b0, MDCB_CLAMP_24V = 1'b1} mdcb_clamp_t;

    typedef logic [15:0] mdcb_word_t;
    typedef logic [7:0]  mdcb_addr_t;

endpackage

// ---- mdcb_config_bank_assertions.sv ----
/*
  Port-level checker of the motor drive configuration bank.
  Assumes binding to mdcb_config_bank in one clock domain.
*/
`timescale 1ns/1ps
module mdcb_config_bank_assertions (
    // clock, reset and host port
    input wire logic                 clock, reset_n, regWrite, regRdHit,
    input wire mdcb_pkg::mdcb_addr_t regAddr,
    input wire mdcb_pkg::mdcb_word_t regWrData, regRdData,
    // settings of the first register
    input wire mdcb_pkg::mdcb_src_t  speedSourceSel,
    input wire mdcb_pkg::mdcb_rate_t switchingRateSel,
    input wire logic [1:0]           torqueConstLockLimits, minOnRatioSel, phaseEdgeSpeedSel,
    input wire logic                 inductiveSurgeGuardOn, mechanicalSurgeGuardOn,
    input wire logic                 rampImmediate, cutoffGivesFullDuty,
    input wire logic [2:0]           closedRampRate,
    input wire logic [3:0]           minDutyFloorPct,
    input wire logic [6:0]           edgeRateVoltsPerUs
);
    import mdcb_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // write and read steps
    // ----------------------------------------
    sequence s_wr_first;
        regWrite && regAddr == 8'h95;
    endsequence

    sequence s_rd_second;
        regAddr == 8'h96;
    endsequence

    a_src_rate_follow: assert property (s_wr_first |=>
        speedSourceSel == $past(regWrData[15]) && switchingRateSel == $past(regWrData[14]))
        else $error("source or rate wrong");
    a_lock_follow: assert property (s_wr_first |=>
        torqueConstLockLimits == $past(regWrData[13:12]))
        else $error("lock limits wrong");
    a_guard_follow: assert property (s_wr_first |=>
        inductiveSurgeGuardOn == $past(regWrData[11])
        && mechanicalSurgeGuardOn == $past(regWrData[10]))
        else $error("guard enables wrong");
    a_ramp_decode: assert property (s_wr_first |=>
        closedRampRate == $past(regWrData[6:4])
        && rampImmediate == ($past(regWrData[6:4]) == 3'h0))
        else $error("ramp wrong");
    a_duty_decode: assert property (s_wr_first |=>
        minOnRatioSel == $past(regWrData[3:2])
        && minDutyFloorPct == ($past(regWrData[2]) ? 4'hA : 4'h5)
        && cutoffGivesFullDuty == $past(regWrData[3]))
        else $error("duty floor wrong");
    // expected rate comes from the written code, not from the select output
    a_edge_decode: assert property (s_wr_first |=>
        phaseEdgeSpeedSel == $past(regWrData[1:0])
        && edgeRateVoltsPerUs == ($past(regWrData[1:0]) == 2'h0 ? 7'h23 :
                                  $past(regWrData[1:0]) == 2'h1 ? 7'h32 :
                                  $past(regWrData[1:0]) == 2'h2 ? 7'h50 : 7'h78))
        else $error("edge rate wrong");
    a_read_rsvd: assert property (s_rd_second |=> regRdHit && !regRdData[7])
        else $error("reserved bit read high");
    a_hold_value: assert property (!(regWrite && regAddr == 8'h95) |=>
        $stable(torqueConstLockLimits) && $stable(closedRampRate))
        else $error("field moved without write");
endmodule

// ---- mdcb_config_bank_test.sv ----
/*
  Self-checking bench of the motor drive configuration bank.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
module mdcb_config_bank_test;
    import mdcb_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRdHit, stayOpenLoop, senseDisabled;
    logic lockHighIsDouble, lockLowIsHalf;
    logic [1:0] postSenseLeadAngle, senseTickSel, loopGainCoefficient;
    logic [3:0] senseCurrentLevel;
    logic [4:0] driverGapTime;
    mdcb_addr_t regAddr = 8'h00, a;
    mdcb_word_t regWrData = 16'h0000, regRdData, m1 = 16'h0000, m2 = 16'h0000;
    mdcb_clamp_t mechanicalSurgeClampTarget;
    mdcb_release_t senseReleaseBehaviour;
    logic [6:0] leadAngleDeg, senseTickHz, driverGapCycles;
    logic [5:0] senseCurrentTenthsA;
    logic [31:0] r;
    int fails = 0, num_checks = 0;

    mdcb_config_bank i_dut (.clock, .reset_n, .regWrite, .regAddr, .regWrData, .regRdData,
        .regRdHit, .speedSourceSel(), .switchingRateSel(), .torqueConstLockLimits(),
        .lockHighIsDouble, .lockLowIsHalf, .inductiveSurgeGuardOn(),
        .mechanicalSurgeGuardOn(), .mechanicalSurgeClampTarget, .senseReleaseBehaviour,
        .stayOpenLoop, .closedRampRate(), .rampImmediate(), .minOnRatioSel(),
        .minDutyFloorPct(), .cutoffGivesFullDuty(), .phaseEdgeSpeedSel(),
        .edgeRateVoltsPerUs(), .postSenseLeadAngle, .leadAngleDeg, .senseCurrentLevel,
        .senseDisabled, .senseCurrentTenthsA, .senseTickSel, .senseTickHz,
        .loopGainCoefficient, .driverGapTime, .driverGapCycles);

    // 50 MHz clock
    always #10 clock = ~clock;

    task check(input mdcb_word_t got, input mdcb_word_t want);
        num_checks++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    // write strobe stays up between writes; each write drives it high again and only a read drops it
    task wr(input mdcb_addr_t ad, input mdcb_word_t d);
        @(negedge clock);
        regWrite = 1'b1; regAddr = ad; regWrData = d;
        if (ad == 8'h95) m1 = d;
        if (ad == 8'h96) m2 = d & 16'hFF7F;
        @(posedge clock);
    endtask

    task rd(input mdcb_addr_t ad);
        @(negedge clock);
        regWrite = 1'b0; regAddr = ad;
        @(posedge clock);
        #1;
        check(regRdData, ad == 8'h95 ? m1 : ad == 8'h96 ? m2 : 16'h0000);
        check({15'h0000, regRdHit}, {15'h0000, ad == 8'h95 || ad == 8'h96});
    endtask

    // decoded settings worked out from the shadow copies
    function automatic logic [6:0] tick_hz(input logic [1:0] c);
        return c == 2'h0 ? 7'h0C : c == 2'h1 ? 7'h18 : c == 2'h2 ? 7'h2F : 7'h5F;
    endfunction

    // code 15 gives 32 tenths, so six bits are needed
    function automatic logic [5:0] curr_tenths(input logic [5:0] c);
        return c == 6'h00 ? 6'h00 : c == 6'h01 ? 6'h04 : (c + 6'h01) << 1;
    endfunction

    task fields;
        logic [5:0] n;
        logic [2:0] t;
        #1;
        n = {2'b00, m2[13:10]};
        t = {mechanicalSurgeClampTarget, senseReleaseBehaviour, stayOpenLoop};
        check({9'h000, leadAngleDeg}, 16'h001E * ({14'h0000, m2[15:14]} + 16'h0001));
        check({10'h000, senseCurrentTenthsA}, {10'h000, curr_tenths(n)});
        check({15'h0000, senseDisabled}, {15'h0000, n == 6'h00});
        check({9'h000, senseTickHz}, {9'h000, tick_hz(m2[9:8])});
        check({9'h000, driverGapCycles}, ({11'h000, m2[4:0]} + 16'h0001) * 16'h0002);
        check(16'(t), 16'(m1[9:7]));
        check(16'({lockLowIsHalf, lockHighIsDouble}), 16'(m1[13:12]));
        check(16'({postSenseLeadAngle, senseTickSel}), 16'({m2[15:14], m2[9:8]}));
        check(16'({senseCurrentLevel, driverGapTime}), 16'({m2[13:10], m2[4:0]}));
        check(16'(loopGainCoefficient), 16'(m2[6:5]));
    endtask

    task give_verdict;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        give_verdict;
    end

    initial begin
        void'($urandom(32'h97041E2C));
        repeat (4) @(negedge clock);
        reset_n = 1'b1;
        rd(8'h95); rd(8'h96); fields;
        $display("test reset values done");
        // back-to-back full writes, reserved bit must not stick
        wr(8'h96, 16'hFFFF); wr(8'h95, 16'hFFFF); fields; rd(8'h96); rd(8'h95);
        wr(8'h94, 16'hA5A5); wr(8'h97, 16'h5A5A); rd(8'h97); rd(8'h96);
        $display("test corners done");
        repeat (300) begin
            r = $urandom;
            a = r[3] ? 8'h95 + {7'h00, r[0]} : r[11:4];
            wr(a, r[31:16]);
            fields;
            rd(r[2] ? 8'h95 + {7'h00, r[1]} : r[19:12]);
        end
        $display("test random traffic done");
        // reset in mid-run clears both registers at once
        @(negedge clock);
        reset_n = 1'b0; m1 = 16'h0000; m2 = 16'h0000;
        fields;
        @(negedge clock);
        reset_n = 1'b1;
        rd(8'h95); rd(8'h96);
        $display("test mid-run reset done");
        give_verdict;
    end
endmodule

bind mdcb_config_bank mdcb_config_bank_assertions i_chk (.clock, .reset_n, .regWrite,
    .regRdHit, .regAddr, .regWrData, .regRdData, .speedSourceSel, .switchingRateSel,
    .torqueConstLockLimits, .minOnRatioSel, .phaseEdgeSpeedSel, .inductiveSurgeGuardOn,
    .mechanicalSurgeGuardOn, .rampImmediate, .cutoffGivesFullDuty, .closedRampRate,
    .minDutyFloorPct, .edgeRateVoltsPerUs);
